// file: sdf_pkg.sv
// Constants and carrier types for the serial data format control block.
package sdf_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          SDF_AW       = 6;
	localparam logic [5:0]  SDF_OFS_FMT  = 6'h00;
	localparam logic [5:0]  SDF_OFS_CTL  = 6'h04;
	localparam logic [5:0]  SDF_OFS_STAT = 6'h08;
	localparam logic [5:0]  SDF_OFS_MASK = 6'h0C;
	localparam logic [1:0]  SDF_OKAY     = 2'h0;
	localparam logic [1:0]  SDF_SLVERR   = 2'h2;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int SDF_CTL_ENA0  = 0;
	localparam int SDF_CTL_MAST  = 3;
	localparam int SDF_CTL_PORT  = 5;
	localparam int SDF_CTL_IRQ   = 7;
	localparam int SDF_ST_FILL   = 0;
	localparam int SDF_ST_CHECK  = 1;
	localparam int SDF_ST_FAULT  = 4;
	localparam int SDF_ST_RXTHR  = 14;

	// ------------------------------------------------------------------
	// Reset values and timing counts
	// ------------------------------------------------------------------
	localparam logic [31:0] SDF_FMT_RST  = 32'h0000_0030;
	localparam logic [7:0]  SDF_MF_MIN   = 8'h02;

	// Format register fields, most significant first.
	typedef struct packed {
		logic       altBus;
		logic       rxThrIrqEn;
		logic [7:0] mfDelay;
		logic [7:0] txCount;
		logic       txDriveEn;
		logic       fillValue;
		logic       directSelEn;
		logic       directSelVal;
		logic       selCtrl;
		logic       selPortMode;
		logic [1:0] bitOrder;
	} sdf_fmt_t;

	// Mode-fault supervision phases.
	typedef enum logic [1:0] {
		SDF_MF_IDLE  = 2'b00,
		SDF_MF_WAIT  = 2'b01,
		SDF_MF_CHECK = 2'b10
	} sdf_mf_t;

endpackage

// file: sdf_format_ctrl.sv
// Serial data format control: fill bytes, sampling, select and mode fault.
// Operation
// [RULE1] Alternate-bus select ignored in slave mode.
// [RULE2] Sample mid-cycle, or at cycle end.
// [RULE3] Bit 24 gates threshold status to interrupt.
// [RULE4] Threshold status flag always kept and readable.
// [RULE5] Count link clocks after release before checking.
// [RULE6] Codes 0 to 2 give two clocks.
// [RULE7] Never check before two clocks.
// [RULE8] Delay only when enabled and master.
// [RULE9] Drive count sets fill bytes, zero endless.
// [RULE10] Start fill on enable-while-empty or new empty.
// [RULE11] Fill bit sets constant serial output level.
// [RULE12] Direct select-enable drives output enable.
// [RULE13] Mode fault sets flag, drops to slave.
// [RULE14] Count fill bytes, stop at programmed count.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sdf_format_ctrl
	import sdf_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [SDF_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [SDF_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              linkClk,
	input  wire logic              selIn,
	input  wire logic              autoSel,
	input  wire logic              txBit,
	input  wire logic              txQueueEmpty,
	input  wire logic              byteDone,
	input  wire logic              rxThrEvent,
	output logic                   selOut,
	output logic                   selOeN,
	output logic                   serOut,
	output logic                   fillDriving,
	output logic                   sampleStrobe,
	output logic                   irq
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              awReady;
		logic              wReady;
		logic              awHeld;
		logic              wHeld;
		logic [SDF_AW-1:0] awAddr;
		logic [31:0]       wData;
		logic [3:0]        wStrb;
		logic              bValid;
		logic [1:0]        bResp;
		logic              arReady;
		logic              rValid;
		logic [31:0]       rData;
		logic [1:0]        rResp;
		sdf_fmt_t          fmt;
		logic [7:0]        ctl;
		logic [31:0]       stat;
		logic [31:0]       mask;
		logic              sclkS1;
		logic              sclkS2;
		logic              sclkS3;
		logic              selS1;
		logic              selS2;
		logic              portEnPrev;
		logic              emptyPrev;
		logic              fillActive;
		logic [7:0]        fillCnt;
		sdf_mf_t           mfPhase;
		logic [7:0]        mfCnt;
		logic              selOut;
		logic              selOeN;
		logic              serOut;
		logic              sample;
		logic              irq;
	} sdf_state_t;

	sdf_state_t q;
	sdf_state_t d;

	// Merges write data into an old word, byte lane by byte lane.
	function automatic logic [31:0] laneMerge(
		input logic [31:0] oldW,
		input logic [31:0] newW,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = oldW;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newW[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// All registers, the bus slave and the serial-side logic in one pass.
	always_comb begin
		logic        wrFire;
		logic        sclkRise;
		logic        sclkFall;
		logic        master;
		logic        mfGate;
		logic        portEnRise;
		logic        emptyRise;
		logic        fillStart;
		logic        released;
		logic [7:0]  mfLimit;
		logic [7:0]  cntNext;
		logic [31:0] w1c;
		logic [31:0] gateBits;
		logic [31:0] merged;
		wrFire     = 1'b0;
		sclkRise   = 1'b0;
		sclkFall   = 1'b0;
		master     = 1'b0;
		mfGate     = 1'b0;
		portEnRise = 1'b0;
		emptyRise  = 1'b0;
		fillStart  = 1'b0;
		released   = 1'b0;
		mfLimit    = 8'h00;
		cntNext    = 8'h00;
		w1c        = 32'h0000_0000;
		gateBits   = 32'h0000_0000;
		merged     = 32'h0000_0000;
		d = q;

		// Two flip-flops on the link clock and select pins before any logic looks at them.
		d.sclkS1 = linkClk;
		d.sclkS2 = q.sclkS1;
		d.sclkS3 = q.sclkS2;
		d.selS1  = selIn;
		d.selS2  = q.selS1;
		sclkRise = q.sclkS2 & ~q.sclkS3;
		sclkFall = ~q.sclkS2 & q.sclkS3;

		// Write address and data are taken independently.
		if (s_axi_awvalid && q.awReady) begin
			d.awHeld = 1'b1;
			d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wReady) begin
			d.wHeld = 1'b1;
			d.wData = s_axi_wdata;
			d.wStrb = s_axi_wstrb;
		end
		if (q.bValid && s_axi_bready) begin
			d.bValid = 1'b0;
		end

		// Register write once both halves are held.
		wrFire = q.awHeld && q.wHeld && !q.bValid;
		if (wrFire) begin
			d.awHeld = 1'b0;
			d.wHeld  = 1'b0;
			d.bValid = 1'b1;
			d.bResp  = SDF_OKAY;
			case (q.awAddr)
				SDF_OFS_FMT: begin
					merged = laneMerge({6'h00, q.fmt}, q.wData, q.wStrb);
					d.fmt  = merged[25:0];
				end
				SDF_OFS_CTL: begin
					merged = laneMerge({24'h0, q.ctl}, q.wData, q.wStrb);
					d.ctl  = merged[7:0] & 8'hA9;
				end
				SDF_OFS_STAT: begin
					w1c = laneMerge(32'h0, q.wData, q.wStrb);
				end
				SDF_OFS_MASK: begin
					d.mask = laneMerge(q.mask, q.wData, q.wStrb)
						& 32'h0000_4010;
				end
				default: begin
					d.bResp = SDF_SLVERR;
				end
			endcase
		end
		d.awReady = !d.awHeld && !d.bValid;
		d.wReady  = !d.wHeld && !d.bValid;

		// Reads answer one cycle after the address is taken.
		if (q.rValid && s_axi_rready) begin
			d.rValid = 1'b0;
		end
		if (s_axi_arvalid && q.arReady) begin
			d.rValid = 1'b1;
			d.rResp  = SDF_OKAY;
			case (s_axi_araddr)
				SDF_OFS_FMT:  d.rData = {6'h00, q.fmt};
				SDF_OFS_CTL:  d.rData = {24'h0, q.ctl};
				SDF_OFS_STAT: d.rData = q.stat;
				SDF_OFS_MASK: d.rData = q.mask;
				default: begin
					d.rData = 32'h0000_0000;
					d.rResp = SDF_SLVERR;
				end
			endcase
		end
		d.arReady = !d.rValid;

		// Software clears first so that a coincident event still sets.
		d.stat = (q.stat & ~w1c) & 32'h0000_4010;
		if (rxThrEvent) begin
			d.stat[SDF_ST_RXTHR] = 1'b1; // [RULE4]
		end

		master = q.ctl[SDF_CTL_MAST];
		mfGate = q.ctl[SDF_CTL_PORT] && q.ctl[SDF_CTL_ENA0] && master;

		// Fill-byte sequencing against the transmit_queue state.
		portEnRise  = q.ctl[SDF_CTL_PORT] & ~q.portEnPrev;
		emptyRise   = txQueueEmpty & ~q.emptyPrev;
		d.portEnPrev = q.ctl[SDF_CTL_PORT];
		d.emptyPrev  = txQueueEmpty;
		fillStart = q.fmt.txDriveEn
			&& ((portEnRise && txQueueEmpty) // [RULE10]
			|| (emptyRise && q.ctl[SDF_CTL_PORT])); // [RULE10]
		cntNext = q.fillCnt + 8'h01;
		if (!q.fmt.txDriveEn || !q.ctl[SDF_CTL_PORT]) begin
			d.fillActive = 1'b0; // [RULE9]
		end else if (q.fillActive && byteDone) begin
			d.fillCnt = cntNext; // [RULE14]
			if (q.fmt.txCount != 8'h00
				&& cntNext == q.fmt.txCount) begin
				d.fillActive = 1'b0; // [RULE9] [RULE14]
			end
		end else if (fillStart && !q.fillActive) begin
			d.fillActive = 1'b1;
			d.fillCnt    = 8'h00;
		end

		// Constant fill level or the shifter's bit on the data line.
		if (d.fillActive || (txQueueEmpty && !master)) begin
			d.serOut = q.fmt.fillValue; // [RULE11]
		end else begin
			d.serOut = txBit;
		end

		// Sampling edge; launch is on the falling link edge.
		if (master && q.fmt.altBus) begin
			d.sample = sclkFall; // [RULE2]
		end else begin
			d.sample = sclkRise; // [RULE1] [RULE2]
		end

		// Select pin drive for each mode combination.
		if (!master) begin
			d.selOut = 1'b1;
			d.selOeN = 1'b1;
		end else if (q.fmt.selCtrl && q.fmt.selPortMode) begin
			d.selOut = q.fmt.directSelVal;
			d.selOeN = q.fmt.directSelEn; // [RULE12]
		end else if (q.fmt.selCtrl) begin
			d.selOut = 1'b0;
			d.selOeN = q.fmt.directSelVal;
		end else if (q.fmt.selPortMode) begin
			d.selOut = autoSel;
			d.selOeN = 1'b0;
		end else begin
			d.selOut = 1'b0;
			d.selOeN = autoSel;
		end

		// Mode-fault supervision after the select driver lets go.
		released = d.selOeN & ~q.selOeN;
		if (q.fmt.mfDelay < SDF_MF_MIN) begin
			mfLimit = SDF_MF_MIN; // [RULE6] [RULE7]
		end else begin
			mfLimit = q.fmt.mfDelay; // [RULE6]
		end
		case (q.mfPhase)
			SDF_MF_IDLE: begin
				if (released && mfGate) begin
					d.mfPhase = SDF_MF_WAIT; // [RULE5]
					d.mfCnt   = 8'h00;
				end
			end
			SDF_MF_WAIT: begin
				if (!mfGate || !q.selOeN) begin
					d.mfPhase = SDF_MF_IDLE; // [RULE8]
				end else if (sclkRise) begin
					d.mfCnt = q.mfCnt + 8'h01; // [RULE5]
					if (q.mfCnt + 8'h01 >= mfLimit) begin
						d.mfPhase = SDF_MF_CHECK; // [RULE7]
					end
				end
			end
			SDF_MF_CHECK: begin
				if (!mfGate || !q.selOeN) begin
					d.mfPhase = SDF_MF_IDLE; // [RULE8]
				end else if (!q.selS2) begin
					d.stat[SDF_ST_FAULT] = 1'b1; // [RULE13]
					d.ctl[SDF_CTL_MAST]  = 1'b0; // [RULE13]
					d.mfPhase = SDF_MF_IDLE;
				end
			end
			default: begin
				d.mfPhase = SDF_MF_IDLE;
			end
		endcase

		// Read-only live bits.
		d.stat[SDF_ST_FILL]  = d.fillActive;
		d.stat[SDF_ST_CHECK] = (d.mfPhase == SDF_MF_CHECK);

		// Enables in the format and control words gate the mask.
		gateBits[SDF_ST_RXTHR] = q.fmt.rxThrIrqEn; // [RULE3]
		gateBits[SDF_ST_FAULT] = q.ctl[SDF_CTL_IRQ]; // [RULE13]
		d.irq = |(d.stat & d.mask & gateBits); // [RULE3]
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Single register bank for the whole block.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.fmt <= SDF_FMT_RST[25:0]; // [RULE12]
			q.selOut <= 1'b1;
			q.selOeN <= 1'b1;
			q.mfPhase <= SDF_MF_IDLE;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Every port below is a flip-flop of the state.
	assign s_axi_awready = q.awReady;
	assign s_axi_wready  = q.wReady;
	assign s_axi_bresp   = q.bResp;
	assign s_axi_bvalid  = q.bValid;
	assign s_axi_arready = q.arReady;
	assign s_axi_rdata   = q.rData;
	assign s_axi_rresp   = q.rResp;
	assign s_axi_rvalid  = q.rValid;
	assign selOut        = q.selOut;
	assign selOeN        = q.selOeN;
	assign serOut        = q.serOut;
	assign fillDriving   = q.fillActive;
	assign sampleStrobe  = q.sample;
	assign irq           = q.irq;

endmodule // sdf_format_ctrl

// file: sdf_spi_peer.sv
// Far-side model: link clock source and the pulled-up select wire.
`timescale 1ns/1ps
module sdf_spi_peer (
	input wire logic run,
	input wire logic peerLow,
	input wire logic selOut,
	input wire logic selOeN,
	output logic     linkClk,
	output logic     selIn
);
	// The link clock runs only within a frame and rests low otherwise.
	initial begin
		linkClk = 1'b0;
		#1;
		forever begin
			#40;
			linkClk = run ? ~linkClk : 1'b0;
		end
	end
	// The pull-up wins unless our driver or the other master pulls low.
	assign selIn = ((!selOeN && !selOut) || peerLow) ? 1'b0 : 1'b1;
endmodule // sdf_spi_peer

// file: sdf_format_ctrl_assertions.sv
// Concurrent checks on the ports of the serial data format control block.
`timescale 1ns/1ps
module sdf_format_ctrl_assertions
	import sdf_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        linkClk,
	input wire logic        txQueueEmpty,
	input wire logic        byteDone,
	input wire logic        fillDriving,
	input wire logic        serOut,
	input wire logic        sampleStrobe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// A write taken whole is answered two edges later.
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	property p_wr_answer;
		s_wr_taken |=> s_wr_answer;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	// Answers stand until they are taken.
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("write answer moved");
	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stands: assert property (p_r_stands) else $error("read answer moved");
	// Fill begins only out of a cycle with an empty transmit queue.
	property p_fill_start;
		$rose(fillDriving) |-> $past(txQueueEmpty);
	endproperty
	a_fill_start: assert property (p_fill_start)
		else $error("fill began");
	// Without a byte or a register update the fill keeps going.
	property p_fill_holds;
		fillDriving && !byteDone && !$past(byteDone) && s_axi_awready
			&& !s_axi_bvalid |=> fillDriving;
	endproperty
	a_fill_holds: assert property (p_fill_holds)
		else $error("fill ended");
	// The fill level stays put while fill runs and no write lands.
	property p_fill_level;
		fillDriving && $past(fillDriving) && s_axi_awready
			&& $past(s_axi_awready) |-> $stable(serOut);
	endproperty
	a_fill_level: assert property (p_fill_level)
		else $error("fill moved");
	// Each sampling strobe follows a link clock edge a few cycles before.
	property p_strobe_edge;
		sampleStrobe |-> $past(linkClk, 3) != $past(linkClk, 6);
	endproperty
	a_strobe_edge: assert property (p_strobe_edge)
		else $error("stray strobe");
endmodule // sdf_format_ctrl_assertions

// file: sdf_format_ctrl_tb.sv
// Self-checking bench for the serial data format control block.
`timescale 1ns/1ps
module sdf_format_ctrl_tb;
	import sdf_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, run = 1'b0, peerLow = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, autoSel = 1'b0;
	logic        txBit = 1'b0, txQueueEmpty = 1'b0, byteDone = 1'b0;
	logic        rxThrEvent = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, selOut, selOeN, serOut, irq;
	logic        fillDriving, sampleStrobe, linkClk, selIn;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	int          error_cnt = 0, cmp_count = 0;

	sdf_format_ctrl sdf_format_ctrl_i (
		.clk           (clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.linkClk       (linkClk),
		.selIn         (selIn),
		.autoSel       (autoSel),
		.txBit         (txBit),
		.txQueueEmpty  (txQueueEmpty),
		.byteDone      (byteDone),
		.rxThrEvent    (rxThrEvent),
		.selOut        (selOut),
		.selOeN        (selOeN),
		.serOut        (serOut),
		.fillDriving   (fillDriving),
		.sampleStrobe  (sampleStrobe),
		.irq           (irq)
	);
	sdf_spi_peer sdf_spi_peer_i (
		.run     (run),
		.peerLow (peerLow),
		.selOut  (selOut),
		.selOeN  (selOeN),
		.linkClk (linkClk),
		.selIn   (selIn)
	);

	// System clock.
	initial begin
		forever #2 clk = ~clk;
	end

	task automatic summarize();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One register access; a write when w is set, else a read.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 99);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rr = w ? s_axi_bresp : s_axi_rresp;
		if (n >= 99) begin
			error_cnt++;
			summarize();
		end
	endtask

	task automatic send_bytes(input int k);
		repeat (k) begin
			@(posedge clk);
			byteDone <= 1'b1;
			@(posedge clk);
			byteDone <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic t_reset();
		bus(1'b0, SDF_OFS_FMT, 32'h0);
		chk(rd, SDF_FMT_RST);
		chk({31'h0, selOeN}, 32'h1);
		bus(1'b0, 6'h10, 32'h0);
		chk({rd[29:0], rr}, {30'h0, SDF_SLVERR});
	endtask

	task automatic t_irq();
		bus(1'b1, SDF_OFS_MASK, 32'h0000_4000);
		rxThrEvent <= 1'b1;
		@(posedge clk);
		rxThrEvent <= 1'b0;
		bus(1'b0, SDF_OFS_STAT, 32'h0);
		chk(rd & 32'h0000_4000, 32'h0000_4000);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, SDF_OFS_FMT, 32'h0100_0030);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, SDF_OFS_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, SDF_OFS_STAT, 32'h0000_4000);
		bus(1'b1, SDF_OFS_MASK, 32'h0000_4000);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_fill();
		bus(1'b1, SDF_OFS_FMT, 32'h0000_02F0);
		bus(1'b1, SDF_OFS_CTL, 32'h0000_0020);
		txQueueEmpty <= 1'b1;
		repeat (3) @(posedge clk);
		chk({30'h0, fillDriving, serOut}, 32'h3);
		send_bytes(1);
		chk({31'h0, fillDriving}, 32'h1);
		send_bytes(1);
		chk({30'h0, fillDriving, serOut}, 32'h1);
		txQueueEmpty <= 1'b0;
		bus(1'b1, SDF_OFS_FMT, 32'h0000_00F0);
		txQueueEmpty <= 1'b1;
		send_bytes(3);
		chk({31'h0, fillDriving}, 32'h1);
		bus(1'b1, SDF_OFS_FMT, 32'h0000_0030);
		repeat (3) @(posedge clk);
		chk({30'h0, fillDriving, serOut}, 32'h0);
		// Port enabled while the queue is already empty, one byte.
		bus(1'b1, SDF_OFS_CTL, 32'h0);
		bus(1'b1, SDF_OFS_FMT, 32'h0000_01F0);
		bus(1'b1, SDF_OFS_CTL, 32'h0000_0020);
		repeat (2) @(posedge clk);
		chk({31'h0, fillDriving}, 32'h1);
		send_bytes(1);
		chk({31'h0, fillDriving}, 32'h0);
	endtask

	task automatic t_fault();
		bus(1'b1, SDF_OFS_MASK, 32'h0000_4010);
		bus(1'b1, SDF_OFS_FMT, 32'h0003_000C);
		bus(1'b1, SDF_OFS_CTL, 32'h0000_00A9);
		repeat (2) @(posedge clk);
		chk({30'h0, selOeN, selOut}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, SDF_OFS_FMT, 32'h0003_002C);
		run <= 1'b1;
		peerLow <= 1'b1;
		repeat (40) @(posedge clk);
		peerLow <= 1'b0;
		repeat (40) @(posedge clk);
		bus(1'b0, SDF_OFS_STAT, 32'h0);
		chk(rd & 32'h0000_0012, 32'h0000_0002);
		peerLow <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, SDF_OFS_STAT, 32'h0);
		chk(rd & 32'h0000_0010, 32'h0000_0010);
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, SDF_OFS_CTL, 32'h0);
		chk(rd, 32'h0000_00A1);
		chk({31'h0, selOeN}, 32'h1);
		peerLow <= 1'b0;
		run <= 1'b0;
	endtask

	// Waits, within a bound, for the next sampling strobe.
	task automatic wait_strobe();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!sampleStrobe && n < 99);
		if (n >= 99) begin
			error_cnt++;
			summarize();
		end
	endtask

	// Link clock level at each strobe shows which edge was sampled.
	task automatic t_sample();
		bus(1'b1, SDF_OFS_FMT, 32'h0203_002C);
		run <= 1'b1;
		wait_strobe();
		chk({31'h0, linkClk}, 32'h1);
		bus(1'b1, SDF_OFS_CTL, 32'h0000_0029);
		wait_strobe();
		chk({31'h0, linkClk}, 32'h0);
		bus(1'b1, SDF_OFS_FMT, 32'h0003_002C);
		wait_strobe();
		chk({31'h0, linkClk}, 32'h1);
		run <= 1'b0;
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_irq();
		t_fill();
		t_fault();
		t_sample();
		summarize();
	end
endmodule // sdf_format_ctrl_tb

bind sdf_format_ctrl sdf_format_ctrl_assertions sdf_format_ctrl_assertions_i (
	.clk           (clk),
	.rst_n         (rst_n),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.s_axi_rdata   (s_axi_rdata),
	.linkClk       (linkClk),
	.txQueueEmpty  (txQueueEmpty),
	.byteDone      (byteDone),
	.fillDriving   (fillDriving),
	.serOut        (serOut),
	.sampleStrobe  (sampleStrobe)
);
